// ===== core/tot_cfg.svh
`ifndef TOT_CFG_SVH
`define TOT_CFG_SVH

// register indices; byte address is four times the index
`define TOT_IDX_CTRL    10'h118
`define TOT_IDX_CMP     10'h11A
`define TOT_IDX_CNT     10'h11B
`define TOT_IDX_LATCH   10'h144
`define TOT_IDX_DIR     10'h145
`define TOT_IDX_FUNC    10'h146

// timer_control field positions
`define TOT_CTRL_LOAD   4
`define TOT_CTRL_LONG   5
`define TOT_CTRL_RUN    6

// port one bit carrying the tone
`define TOT_PIN_BIT     7

// reset values
`define TOT_RST_CTRL    8'h00
`define TOT_RST_RELOAD  8'h00
`define TOT_RST_CMP     8'h00
`define TOT_RST_LATCH   8'h00
`define TOT_RST_DIR     8'h00
`define TOT_RST_FUNC    8'hBF

// counter limit before reload
`define TOT_CNT_TOP     8'hFF

`endif

// ===== core/tot_pkg.sv
package tot_pkg;
  typedef logic [7:0]  tot_byte_t;
  typedef logic [11:0] tot_adr_t;
  typedef logic [31:0] tot_word_t;
  typedef logic [3:0]  tot_sel_t;
endpackage

// ===== core/tot_counter.sv
`include "tot_cfg.svh"

module tot_counter (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          run,
  input  wire logic          load_en,
  input  wire tot_pkg::tot_byte_t reload_in,
  input  wire tot_pkg::tot_byte_t cmp_in,
  output tot_pkg::tot_byte_t      cnt_o,
  output logic                    low_o
);
  import tot_pkg::*;

  tot_byte_t cnt_r;
  tot_byte_t rl_eff_r;
  tot_byte_t cmp_eff_r;
  tot_byte_t rl_eff_nxt;
  tot_byte_t cmp_eff_nxt;
  tot_byte_t cnt_nxt;
  logic      wrap;

  assign rl_eff_nxt  = load_en ? reload_in : rl_eff_r;
  assign cmp_eff_nxt = load_en ? cmp_in : cmp_eff_r;

  assign wrap = run && (cnt_r == `TOT_CNT_TOP);

  assign cnt_nxt = !run ? rl_eff_r : (wrap ? rl_eff_r : cnt_r + 8'h01);

  assign low_o = run && (cnt_r < cmp_eff_r);
  assign cnt_o = cnt_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r     <= `TOT_RST_RELOAD;
      rl_eff_r  <= `TOT_RST_RELOAD;
      cmp_eff_r <= `TOT_RST_CMP;
    end else begin
      cnt_r     <= cnt_nxt;
      rl_eff_r  <= rl_eff_nxt;
      cmp_eff_r <= cmp_eff_nxt;
    end
  end

  // helper: cycles and low cycles since last wrap, valid only over clean periods
  logic [8:0] per_r;
  logic [8:0] lowc_r;
  logic       clean_r;
  logic [8:0] exp_low;
  assign exp_low = (cmp_eff_r > rl_eff_r) ? {1'b0, cmp_eff_r - rl_eff_r} : 9'h000;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      per_r   <= 9'h000;
      lowc_r  <= 9'h000;
      clean_r <= 1'b0;
    end else begin
      per_r   <= wrap ? 9'h000 : per_r + 9'h001;
      lowc_r  <= wrap ? 9'h000 : lowc_r + {8'h00, low_o};
      clean_r <= (wrap || clean_r) && run && (rl_eff_nxt == rl_eff_r)
                 && (cmp_eff_nxt == cmp_eff_r);
    end
  end

  AST_HOLD_PARAMS: assert property (@(posedge clk) disable iff (!nrst)
    !load_en |=> (rl_eff_r == $past(rl_eff_r)) && (cmp_eff_r == $past(cmp_eff_r)))
    else $error("parameters changed while load disabled");

  AST_APPLY_PARAMS: assert property (@(posedge clk) disable iff (!nrst)
    load_en |=> (rl_eff_r == $past(reload_in)) && (cmp_eff_r == $past(cmp_in)))
    else $error("parameters not applied at once");

  AST_RELOAD_ON_OVF: assert property (@(posedge clk) disable iff (!nrst)
    wrap |=> cnt_r == $past(rl_eff_r))
    else $error("counter did not reload on overflow");

  AST_COUNT_UP: assert property (@(posedge clk) disable iff (!nrst)
    run && !wrap |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("running counter did not advance");

  AST_STOP_HOLDS: assert property (@(posedge clk) disable iff (!nrst)
    !run [*2] |-> cnt_r == $past(rl_eff_r))
    else $error("stopped counter not at reload value");

  AST_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
    wrap && clean_r |-> per_r == {1'b0, `TOT_CNT_TOP - rl_eff_r})
    else $error("period not 256 minus reload");

  AST_LOW_WIDTH: assert property (@(posedge clk) disable iff (!nrst)
    wrap && clean_r |-> lowc_r == exp_low)
    else $error("low phase not compare minus reload");

  CV_CLEAN_PERIOD: cover property (@(posedge clk) disable iff (!nrst)
    wrap && clean_r && (exp_low != 9'h000));
endmodule

// ===== core/tot_tone_timer.sv
// How it works
// - low phase lasts compare value minus reload value in clock cycles
// - output period is 256 minus reload value cycles
// - new reload or compare values ignored unless compare-load enable is set
// - with compare-load enable set, written parameters apply at once
// - writing run bit one starts the counter and tone
// - clearing run bit stops the counter and tone
// - running lower counter counts and its compare drives the pin
// - on overflow the counter loads the reload value and continues
// - eight bit comparator continuously checks counter against compare
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`include "tot_cfg.svh"

module tot_tone_timer (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire tot_pkg::tot_adr_t   wb_adr_i,
  input  wire tot_pkg::tot_sel_t   wb_sel_i,
  input  wire tot_pkg::tot_word_t  wb_dat_i,
  output tot_pkg::tot_word_t       wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     tone_pin_o,
  output logic                     tone_pin_oe
);
  import tot_pkg::*;

  tot_byte_t ctrl_r;
  tot_byte_t reload_r;
  tot_byte_t cmp_r;
  tot_byte_t latch_r;
  tot_byte_t dir_r;
  tot_byte_t func_r;
  tot_word_t dat_r;
  logic      ack_r;
  logic      pin_r;
  logic      oe_r;

  tot_byte_t cnt;
  logic      low;

  // bus decode
  logic [9:0] idx;
  logic       req;
  logic       wr_go;
  logic       wr_byte;
  logic       hit_ctrl;
  logic       hit_cmp;
  logic       hit_cnt;
  logic       hit_latch;
  logic       hit_dir;
  logic       hit_func;
  tot_byte_t  wdat;
  tot_byte_t  rd_byte;
  tot_byte_t  ctrl_mask;

  assign idx       = wb_adr_i[11:2];
  assign req       = wb_cyc_i && wb_stb_i;
  // writes land on the edge where the master sees ack
  assign wr_go     = req && wb_we_i && ack_r;
  assign wr_byte   = wr_go && wb_sel_i[0];
  assign wdat      = wb_dat_i[7:0];
  assign hit_ctrl  = (idx == `TOT_IDX_CTRL);
  assign hit_cmp   = (idx == `TOT_IDX_CMP);
  assign hit_cnt   = (idx == `TOT_IDX_CNT);
  assign hit_latch = (idx == `TOT_IDX_LATCH);
  assign hit_dir   = (idx == `TOT_IDX_DIR);
  assign hit_func  = (idx == `TOT_IDX_FUNC);

  // only the low-timer bits are kept; high-timer bits read zero
  assign ctrl_mask = (8'h01 << `TOT_CTRL_LOAD) | (8'h01 << `TOT_CTRL_LONG)
                   | (8'h01 << `TOT_CTRL_RUN);

  // counter shares its index with the write-only reload value
  assign rd_byte = hit_ctrl  ? ctrl_r :
                   hit_cmp   ? cmp_r :
                   hit_cnt   ? cnt :
                   hit_latch ? latch_r :
                   hit_dir   ? dir_r :
                   hit_func  ? func_r : 8'h00;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req && !ack_r;
      dat_r <= {24'h00_0000, rd_byte};
    end
  end

  // software registers; unmapped writes are acknowledged and dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r   <= `TOT_RST_CTRL;
      reload_r <= `TOT_RST_RELOAD;
      cmp_r    <= `TOT_RST_CMP;
      latch_r  <= `TOT_RST_LATCH;
      dir_r    <= `TOT_RST_DIR;
      func_r   <= `TOT_RST_FUNC;
    end else if (wr_byte) begin
      if (hit_ctrl)
        ctrl_r <= wdat & ctrl_mask;
      if (hit_cnt)
        reload_r <= wdat;
      if (hit_cmp)
        cmp_r <= wdat;
      if (hit_latch)
        latch_r <= wdat;
      if (hit_dir)
        dir_r <= wdat;
      if (hit_func)
        func_r <= wdat;
    end
  end

  logic run;
  logic load_en;
  logic tone_sel;

  assign run     = ctrl_r[`TOT_CTRL_RUN];
  assign load_en = ctrl_r[`TOT_CTRL_LOAD];
  assign tone_sel = !ctrl_r[`TOT_CTRL_LONG] && func_r[`TOT_PIN_BIT];

  tot_counter u_counter (
    .clk       (clk),
    .nrst      (nrst),
    .run       (run),
    .load_en   (load_en),
    .reload_in (reload_r),
    .cmp_in    (cmp_r),
    .cnt_o     (cnt),
    .low_o     (low)
  );

  logic pin_nxt;
  assign pin_nxt = tone_sel ? !low : latch_r[`TOT_PIN_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_r <= 1'b1;
      oe_r  <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
      oe_r  <= dir_r[`TOT_PIN_BIT];
    end
  end

  assign wb_dat_o    = dat_r;
  assign wb_ack_o    = ack_r;
  assign tone_pin_o  = pin_r;
  assign tone_pin_oe = oe_r;

  AST_PIN_HIGH_STOPPED: assert property (@(posedge clk) disable iff (!nrst)
    (tone_sel && !run) [*2] |-> pin_r)
    else $error("pin not high while counter stopped");

  AST_PIN_FOLLOWS_LOW: assert property (@(posedge clk) disable iff (!nrst)
    tone_sel && low |=> !pin_r)
    else $error("pin not low during low phase");

  AST_RUN_START: assert property (@(posedge clk) disable iff (!nrst)
    wr_byte && hit_ctrl && wdat[`TOT_CTRL_RUN] |=> run ##1 (cnt != $past(cnt)))
    else $error("run write did not start counter");

  AST_RUN_STOP: assert property (@(posedge clk) disable iff (!nrst)
    wr_byte && hit_ctrl && !wdat[`TOT_CTRL_RUN] |=> !run ##2 pin_r || !tone_sel)
    else $error("clearing run did not stop tone");

  AST_ACK_ONE: assert property (@(posedge clk) disable iff (!nrst)
    ack_r |=> !ack_r)
    else $error("ack held more than one cycle");

  // every taken request is answered one cycle later, mapped or not
  AST_ACK_AFTER_REQ: assert property (@(posedge clk) disable iff (!nrst)
    req && !ack_r |=> ack_r)
    else $error("request not acknowledged in the next cycle");

  AST_ACK_NEEDS_REQ: assert property (@(posedge clk) disable iff (!nrst)
    ack_r |-> $past(req))
    else $error("ack without a request");

  AST_CTRL_MASKED: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl_r & ~ctrl_mask) == 8'h00)
    else $error("unimplemented control bits set");

  AST_RUN_IS_BIT: assert property (@(posedge clk) disable iff (!nrst)
    wr_byte && hit_ctrl |=> run == $past(wdat[`TOT_CTRL_RUN]))
    else $error("run does not follow written control bit");

  AST_CMP_LANDS: assert property (@(posedge clk) disable iff (!nrst)
    wr_byte && hit_cmp |=> cmp_r == $past(wdat))
    else $error("compare write lost");

  AST_RELOAD_LANDS: assert property (@(posedge clk) disable iff (!nrst)
    wr_byte && hit_cnt |=> reload_r == $past(wdat))
    else $error("reload write lost");

  AST_PIN_HIGH_PHASE: assert property (@(posedge clk) disable iff (!nrst)
    tone_sel && !low |=> pin_r)
    else $error("pin low outside the low phase");

  // outside tone mode the pin is a plain port bit
  AST_LATCH_PIN: assert property (@(posedge clk) disable iff (!nrst)
    !tone_sel |=> pin_r == $past(latch_r[`TOT_PIN_BIT]))
    else $error("pin does not follow the latch bit");

  AST_OE_DRIVE: assert property (@(posedge clk) disable iff (!nrst)
    dir_r[`TOT_PIN_BIT] |=> oe_r)
    else $error("pin not driven with direction bit set");

  CV_TONE_RUNNING: cover property (@(posedge clk) disable iff (!nrst)
    tone_sel && run && oe_r ##1 !pin_r ##[1:300] pin_r);
  CV_LIVE_RETUNE: cover property (@(posedge clk) disable iff (!nrst)
    run && load_en && wr_byte && hit_cnt);
  CV_STOP: cover property (@(posedge clk) disable iff (!nrst)
    run ##1 !run);
  CV_LATCH_MODE: cover property (@(posedge clk) disable iff (!nrst)
    !tone_sel && oe_r && pin_r);
endmodule

// ===== testbench/tot_buzzer_model.sv
module tot_buzzer_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        pin_i,
  input  wire logic        oe_i,
  output logic [15:0]      low_len,
  output logic [15:0]      period_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] low_cnt_r;
  logic [15:0] per_cnt_r;
  logic        last_r;
  // an undriven pin leaves the buzzer silent, read as high
  wire         level = oe_i ? pin_i : 1'b1;

  // lengths are measured fall to fall and fall to rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_r  <= 16'h0000;
      per_cnt_r  <= 16'h0000;
      last_r     <= 1'b1;
      low_len    <= 16'h0000;
      period_len <= 16'h0000;
    end else begin
      last_r    <= level;
      per_cnt_r <= per_cnt_r + 16'h0001;
      low_cnt_r <= level ? low_cnt_r : low_cnt_r + 16'h0001;
      if (last_r && !level) begin
        period_len <= per_cnt_r;
        per_cnt_r  <= 16'h0001;
        low_cnt_r  <= 16'h0001;
      end
      if (!last_r && level) begin
        low_len <= low_cnt_r;
      end
    end
  end
endmodule

// ===== testbench/tot_tone_timer_bench.sv
`include "tot_cfg.svh"

module tot_tone_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tot_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  tot_adr_t    adr = 12'h000;
  tot_sel_t    sel = 4'h0;
  tot_word_t   wdat = 32'h0;
  tot_word_t   rdat;
  logic        ack;
  logic        pin;
  logic        oe;
  logic [15:0] low_len;
  logic [15:0] period_len;
  int          fail_count = 0;
  int          checks = 0;

  always #5 clk = ~clk;

  tot_tone_timer tot_tone_timer_inst (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tone_pin_o(pin), .tone_pin_oe(oe));
  tot_buzzer_model tot_buzzer_model_inst (.clk(clk), .nrst(nrst), .pin_i(pin), .oe_i(oe),
    .low_len(low_len), .period_len(period_len));

  task automatic close_out();
    if (fail_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                    output tot_word_t q);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= 4'h1;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 20) chk("bus ack", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    tot_word_t q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rdchk(input string what, input logic [9:0] idx, input logic [7:0] exp);
    tot_word_t q;
    wb(1'b0, idx, 8'h00, q);
    chk(what, {24'h000000, exp}, q);
  endtask

  task automatic tone_chk(input logic [15:0] per, input logic [15:0] low);
    repeat (600) @(posedge clk);
    chk("period", {16'h0, per}, {16'h0, period_len});
    chk("low phase", {16'h0, low}, {16'h0, low_len});
  endtask

  task automatic t_reset();
    chk("pin idle", 32'h1, {31'h0, pin});
    chk("pin enable", 32'h0, {31'h0, oe});
    rdchk("control", `TOT_IDX_CTRL, `TOT_RST_CTRL);
    rdchk("compare", `TOT_IDX_CMP, `TOT_RST_CMP);
    rdchk("latch", `TOT_IDX_LATCH, `TOT_RST_LATCH);
    rdchk("direction", `TOT_IDX_DIR, `TOT_RST_DIR);
    rdchk("function", `TOT_IDX_FUNC, `TOT_RST_FUNC);
    wr(10'h000, 8'h5A);
    rdchk("unmapped", 10'h000, 8'h00);
  endtask

  task automatic t_tone();
    // mode setup done by software
    wr(`TOT_IDX_DIR, 8'h80);
    wr(`TOT_IDX_FUNC, 8'h80);
    wr(`TOT_IDX_LATCH, 8'h00);
    wr(`TOT_IDX_CNT, 8'hC0);
    wr(`TOT_IDX_CMP, 8'hE0);
    wr(`TOT_IDX_CTRL, 8'h50);
    tone_chk(16'h0040, 16'h0020);
    chk("pin enable", 32'h1, {31'h0, oe});
    rdchk("control", `TOT_IDX_CTRL, 8'h50);
  endtask

  task automatic t_hold();
    wr(`TOT_IDX_CTRL, 8'h40);
    wr(`TOT_IDX_CNT, 8'hF0);
    wr(`TOT_IDX_CMP, 8'hF8);
    tone_chk(16'h0040, 16'h0020);
    wr(`TOT_IDX_CTRL, 8'h50);
    tone_chk(16'h0010, 16'h0008);
    wr(`TOT_IDX_CNT, 8'h80);
    wr(`TOT_IDX_CMP, 8'hC0);
    tone_chk(16'h0080, 16'h0040);
  endtask

  task automatic t_stop();
    int lows;
    lows = 0;
    wr(`TOT_IDX_CTRL, 8'h10);
    repeat (5) @(posedge clk);
    repeat (300) begin
      @(posedge clk);
      if (pin !== 1'b1) lows++;
    end
    chk("stopped low cycles", 32'h0, lows);
    wr(`TOT_IDX_CTRL, 8'h50);
    tone_chk(16'h0080, 16'h0040);
  endtask

  // long mode or a cleared function bit hands the pin back to the latch
  task automatic t_latch();
    int highs;
    highs = 0;
    wr(`TOT_IDX_CTRL, 8'hFF);
    rdchk("control mask", `TOT_IDX_CTRL, 8'h70);
    repeat (300) begin
      @(posedge clk);
      if (pin !== 1'b0) highs++;
    end
    chk("long mode high cycles", 32'h0, highs);
    wr(`TOT_IDX_FUNC, 8'h00);
    wr(`TOT_IDX_LATCH, 8'h80);
    repeat (2) @(posedge clk);
    chk("latch pin", 32'h1, {31'h0, pin});
  endtask

  initial begin
    #200000;
    fail_count++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_tone();
    t_hold();
    t_stop();
    t_latch();
    close_out();
  end
endmodule
